// ### afe_pkg.sv
// Shared constants, state encodings and helpers for the AXI front end
package afe_pkg;

  // ----------------------------------------------------------------
  // Bus and storage dimensions
  // ----------------------------------------------------------------
  localparam int ADDR_W     = 32;
  localparam int DATA_W     = 32;
  localparam int STRB_W     = 4;
  localparam int ID_W       = 4;
  localparam int LEN_W      = 4;
  localparam int SIZE_W     = 3;
  localparam int BUF_DEPTH  = 16;
  localparam int NUM_MON    = 2;
  localparam int NUM_CHIP   = 4;

  // ----------------------------------------------------------------
  // Address formatting
  // ----------------------------------------------------------------
  localparam int CS_HI      = 31;
  localparam int CS_LO      = 24;
  localparam int CS_W       = 8;
  localparam int ROW_W      = 16;
  localparam int COL_W      = 12;
  localparam int BANK_W     = 2;
  localparam int ROW_BASE   = 11;
  localparam int COL_BASE   = 8;
  localparam int WORD_SHIFT = 2;
  localparam int GEOM_W     = 3;

  // ----------------------------------------------------------------
  // Responses and write channel states
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_EXOKAY = 2'h1;

  typedef enum logic [2:0] {
    W_IDLE   = 3'h0,
    W_DATA   = 3'h1,
    W_ISSUE  = 3'h2,
    W_COMMIT = 3'h3,
    W_RESP   = 3'h4
  } afe_wstate_t;

  // Mask clearing every bit up to the top varying bit of an incrementing span
  function automatic logic [ADDR_W-1:0] span_mask(input logic [ADDR_W-1:0] a,
                                                  input logic [LEN_W-1:0]  len,
                                                  input logic [SIZE_W-1:0] size);
    logic [ADDR_W-1:0] bytes;
    logic [ADDR_W-1:0] diff;
    logic [ADDR_W-1:0] m;
    bytes = (ADDR_W'(len) + ADDR_W'(1)) << size;
    diff  = a ^ (a + bytes - ADDR_W'(1));
    m     = '1;
    for (int i = 0; i < ADDR_W; i++) begin
      if (diff[i]) begin
        m = ~((ADDR_W'(2) << i) - ADDR_W'(1));
      end
    end
    return m;
  endfunction

  // Field of a word address: shift down, keep a given number of bits
  function automatic logic [ADDR_W-1:0] addr_field(input logic [ADDR_W-1:0] v,
                                                   input int sh,
                                                   input int w);
    return (v >> sh) & ((ADDR_W'(1) << w) - ADDR_W'(1));
  endfunction

endpackage

// ### afe_addr_dec.sv
// Chip, row, column and bank decode of one AXI address
`timescale 1ns/10ps
module afe_addr_dec (
  input  wire logic [afe_pkg::ADDR_W-1:0]           addr,
  input  wire logic [afe_pkg::NUM_CHIP*afe_pkg::CS_W-1:0] chip_match,
  input  wire logic [afe_pkg::NUM_CHIP*afe_pkg::CS_W-1:0] chip_mask,
  input  wire logic [afe_pkg::NUM_CHIP-1:0]         chip_fmt,
  input  wire logic [afe_pkg::GEOM_W-1:0]           row_code,
  input  wire logic [afe_pkg::GEOM_W-1:0]           col_code,
  output logic      [afe_pkg::NUM_CHIP-1:0]         chip_sel,
  output logic      [afe_pkg::ROW_W-1:0]            row,
  output logic      [afe_pkg::COL_W-1:0]            col,
  output logic      [afe_pkg::BANK_W-1:0]           bank
);
  import afe_pkg::*;

  logic              fmt;
  logic [ADDR_W-1:0] wa;
  int                roww;
  int                colw;

  // ----------------------------------------------------------------
  // Chip select: lowest matching chip wins, no match leaves none
  // ----------------------------------------------------------------
  always_comb begin
    chip_sel = '0;
    fmt      = 1'b0;
    for (int i = NUM_CHIP - 1; i >= 0; i--) begin
      if (((addr[CS_HI:CS_LO] ^ chip_match[i*CS_W +: CS_W]) & chip_mask[i*CS_W +: CS_W]) == '0) begin
        chip_sel = NUM_CHIP'(1) << i;
        fmt      = chip_fmt[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Row, column, bank split of the word address
  // ----------------------------------------------------------------
  always_comb begin
    wa   = addr >> WORD_SHIFT;
    roww = ROW_BASE + int'(row_code);
    colw = COL_BASE + int'(col_code);
    col  = COL_W'(addr_field(wa, 0, colw));
    if (fmt) begin
      // Bank above row
      row  = ROW_W'(addr_field(wa, colw, roww));
      bank = BANK_W'(addr_field(wa, colw + roww, BANK_W));
    end else begin
      // Bank between row and column
      bank = BANK_W'(addr_field(wa, colw, BANK_W));
      row  = ROW_W'(addr_field(wa, colw + BANK_W, roww));
    end
  end

endmodule

// ### afe_excl_mon.sv
// Bank of exclusive access monitors with conservative masked compare
`timescale 1ns/10ps
module afe_excl_mon (
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  input  wire logic                        arm,
  input  wire logic [afe_pkg::ID_W-1:0]    arm_id,
  input  wire logic [afe_pkg::ADDR_W-1:0]  arm_addr,
  input  wire logic                        wr_chk,
  input  wire logic [afe_pkg::ID_W-1:0]    wr_id,
  input  wire logic [afe_pkg::ADDR_W-1:0]  wr_addr,
  input  wire logic [afe_pkg::LEN_W-1:0]   wr_len,
  input  wire logic [afe_pkg::SIZE_W-1:0]  wr_size,
  input  wire logic                        wr_excl,
  output logic                             excl_pass
);
  import afe_pkg::*;

  logic [NUM_MON-1:0] vld_r;
  logic [NUM_MON-1:0] hit_r;
  logic [ID_W-1:0]    id_r   [NUM_MON];
  logic [ADDR_W-1:0]  addr_r [NUM_MON];
  logic [ADDR_W-1:0]  wmask;
  int                 arm_idx;

  // ----------------------------------------------------------------
  // Lookup: pass test and choice of monitor to arm
  // ----------------------------------------------------------------
  always_comb begin
    wmask     = span_mask(wr_addr, wr_len, wr_size);
    excl_pass = 1'b0;
    arm_idx   = 0;
    for (int i = NUM_MON - 1; i >= 0; i--) begin
      if (!vld_r[i]) begin
        arm_idx = i;
      end
    end
    for (int i = 0; i < NUM_MON; i++) begin
      if (vld_r[i] && id_r[i] == wr_id && !hit_r[i]) begin
        excl_pass = 1'b1;
      end
      if (vld_r[i] && id_r[i] == arm_id) begin
        arm_idx = i;
      end
    end
  end

  // ----------------------------------------------------------------
  // Monitor state: arming wins over a snoop in the same cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      vld_r <= '0;
      hit_r <= '0;
    end else begin
      for (int i = 0; i < NUM_MON; i++) begin
        if (wr_chk && vld_r[i] && id_r[i] != wr_id && ((addr_r[i] ^ wr_addr) & wmask) == '0) begin
          hit_r[i] <= 1'b1;
        end
        if (wr_chk && wr_excl && vld_r[i] && id_r[i] == wr_id) begin
          vld_r[i] <= 1'b0;
        end
      end
      if (arm) begin
        vld_r[arm_idx] <= 1'b1;
        hit_r[arm_idx] <= 1'b0;
      end
    end
  end

  // Tag and address of each monitor
  always_ff @(posedge clk) begin
    if (arm) begin
      id_r[arm_idx]   <= arm_id;
      addr_r[arm_idx] <= arm_addr;
    end
  end

endmodule

// ### afe_axi_front.sv
// AXI slave front end: early write response, address decode, exclusive monitors
//
// Operation
// - Early response once last beat buffered
// - Keep read/write ordering with early responses
// - Exclusive write responds only after commit
// - Match address top byte per chip, masked
// - Unmatched address still transferred, result undefined
// - Row from geometry row code and format
// - Column from geometry column code
// - Bank from build layout and format bit
// - EXOKAY for exclusive success, else OKAY
// - Configurable monitor count, one access each
// - Failed exclusive write stores no bytes
// - Other masters' writes checked against monitors
// - Mask off bits up to top varying bit
// - Every burst treated as incrementing
`timescale 1ns/10ps
module afe_axi_front (
  input  wire logic                                        clk,
  input  wire logic                                        sys_rst,
  // Configuration
  input  wire logic                                        early_resp_en,
  input  wire logic [afe_pkg::GEOM_W-1:0]                  geom_row_code,
  input  wire logic [afe_pkg::GEOM_W-1:0]                  geom_col_code,
  input  wire logic [afe_pkg::NUM_CHIP*afe_pkg::CS_W-1:0]  chip_match,
  input  wire logic [afe_pkg::NUM_CHIP*afe_pkg::CS_W-1:0]  chip_mask,
  input  wire logic [afe_pkg::NUM_CHIP-1:0]                chip_fmt,
  // Write address channel
  input  wire logic                                        awvalid,
  output logic                                             awready,
  input  wire logic [afe_pkg::ID_W-1:0]                    awid,
  input  wire logic [afe_pkg::ADDR_W-1:0]                  awaddr,
  input  wire logic [afe_pkg::LEN_W-1:0]                   awlen,
  input  wire logic [afe_pkg::SIZE_W-1:0]                  awsize,
  input  wire logic                                        awlock,
  // Write data channel
  input  wire logic                                        wvalid,
  output logic                                             wready,
  input  wire logic [afe_pkg::DATA_W-1:0]                  wdata,
  input  wire logic [afe_pkg::STRB_W-1:0]                  wstrb,
  input  wire logic                                        wlast,
  // Write response channel
  output logic                                             bvalid,
  input  wire logic                                        bready,
  output logic      [afe_pkg::ID_W-1:0]                    bid,
  output logic      [1:0]                                  bresp,
  // Read address channel
  input  wire logic                                        arvalid,
  output logic                                             arready,
  input  wire logic [afe_pkg::ID_W-1:0]                    arid,
  input  wire logic [afe_pkg::ADDR_W-1:0]                  araddr,
  input  wire logic [afe_pkg::LEN_W-1:0]                   arlen,
  input  wire logic [afe_pkg::SIZE_W-1:0]                  arsize,
  input  wire logic                                        arlock,
  // Memory-side write command and data
  output logic                                             mem_wr_valid,
  input  wire logic                                        mem_wr_ready,
  output logic      [afe_pkg::DATA_W-1:0]                  mem_wr_data,
  output logic      [afe_pkg::STRB_W-1:0]                  mem_wr_strb,
  output logic                                             mem_wr_last,
  output logic      [afe_pkg::NUM_CHIP-1:0]                mem_wr_chip,
  output logic      [afe_pkg::ROW_W-1:0]                   mem_wr_row,
  output logic      [afe_pkg::COL_W-1:0]                   mem_wr_col,
  output logic      [afe_pkg::BANK_W-1:0]                  mem_wr_bank,
  input  wire logic                                        mem_wr_done,
  // Memory-side read command
  output logic                                             mem_rd_valid,
  input  wire logic                                        mem_rd_ready,
  output logic      [afe_pkg::ID_W-1:0]                    mem_rd_id,
  output logic      [afe_pkg::LEN_W-1:0]                   mem_rd_len,
  output logic      [afe_pkg::SIZE_W-1:0]                  mem_rd_size,
  output logic      [1:0]                                  mem_rd_resp,
  output logic      [afe_pkg::NUM_CHIP-1:0]                mem_rd_chip,
  output logic      [afe_pkg::ROW_W-1:0]                   mem_rd_row,
  output logic      [afe_pkg::COL_W-1:0]                   mem_rd_col,
  output logic      [afe_pkg::BANK_W-1:0]                  mem_rd_bank,
  // Status
  output logic                                             wr_busy
);
  import afe_pkg::*;

  // ----------------------------------------------------------------
  // State and storage
  // ----------------------------------------------------------------
  afe_wstate_t         wstate_r;
  logic [LEN_W-1:0]    aw_len_r;
  logic                aw_excl_r;
  logic                aw_pass_r;
  logic                early_r;
  logic                b_done_r;
  logic [LEN_W-1:0]    wr_idx_r;
  logic [LEN_W-1:0]    iss_idx_r;
  logic [DATA_W-1:0]   wbuf_data [BUF_DEPTH];
  logic [STRB_W-1:0]   wbuf_strb [BUF_DEPTH];

  logic                awready_r;
  logic                wready_r;
  logic                bvalid_r;
  logic [ID_W-1:0]     bid_r;
  logic [1:0]          bresp_r;
  logic                arready_r;
  logic                mem_wr_valid_r;
  logic [DATA_W-1:0]   mem_wr_data_r;
  logic [STRB_W-1:0]   mem_wr_strb_r;
  logic                mem_wr_last_r;
  logic [NUM_CHIP-1:0] mem_wr_chip_r;
  logic [ROW_W-1:0]    mem_wr_row_r;
  logic [COL_W-1:0]    mem_wr_col_r;
  logic [BANK_W-1:0]   mem_wr_bank_r;
  logic                mem_rd_valid_r;
  logic [ID_W-1:0]     mem_rd_id_r;
  logic [LEN_W-1:0]    mem_rd_len_r;
  logic [SIZE_W-1:0]   mem_rd_size_r;
  logic [1:0]          mem_rd_resp_r;
  logic [NUM_CHIP-1:0] mem_rd_chip_r;
  logic [ROW_W-1:0]    mem_rd_row_r;
  logic [COL_W-1:0]    mem_rd_col_r;
  logic [BANK_W-1:0]   mem_rd_bank_r;
  logic                wr_busy_r;

  logic [NUM_CHIP-1:0] aw_chip;
  logic [ROW_W-1:0]    aw_row;
  logic [COL_W-1:0]    aw_col;
  logic [BANK_W-1:0]   aw_bank;
  logic [NUM_CHIP-1:0] ar_chip;
  logic [ROW_W-1:0]    ar_row;
  logic [COL_W-1:0]    ar_col;
  logic [BANK_W-1:0]   ar_bank;
  logic                mon_pass;

  // Handshakes
  wire aw_fire     = awvalid && awready_r;
  wire w_fire      = wvalid && wready_r;
  wire w_last_beat = w_fire && (wlast || wr_idx_r == aw_len_r);
  wire b_fire      = bvalid_r && bready;
  wire ar_fire     = arvalid && arready_r;
  wire mw_fire     = mem_wr_valid_r && mem_wr_ready;
  wire mw_load     = (wstate_r == W_ISSUE) && (!mem_wr_valid_r || (mem_wr_ready && !mem_wr_last_r));

  // ----------------------------------------------------------------
  // Address decoders and exclusive monitors
  // ----------------------------------------------------------------
  afe_addr_dec u_aw_dec (
    .addr       (awaddr),
    .chip_match (chip_match),
    .chip_mask  (chip_mask),
    .chip_fmt   (chip_fmt),
    .row_code   (geom_row_code),
    .col_code   (geom_col_code),
    .chip_sel   (aw_chip),
    .row        (aw_row),
    .col        (aw_col),
    .bank       (aw_bank)
  );

  afe_addr_dec u_ar_dec (
    .addr       (araddr),
    .chip_match (chip_match),
    .chip_mask  (chip_mask),
    .chip_fmt   (chip_fmt),
    .row_code   (geom_row_code),
    .col_code   (geom_col_code),
    .chip_sel   (ar_chip),
    .row        (ar_row),
    .col        (ar_col),
    .bank       (ar_bank)
  );

  afe_excl_mon u_mon (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .arm       (ar_fire && arlock),
    .arm_id    (arid),
    .arm_addr  (araddr),
    .wr_chk    (aw_fire),
    .wr_id     (awid),
    .wr_addr   (awaddr),
    .wr_len    (awlen),
    .wr_size   (awsize),
    .wr_excl   (awlock),
    .excl_pass (mon_pass)
  );

  // ----------------------------------------------------------------
  // Address acceptance: one write at a time; only a read accepted in the same cycle overlaps it
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      awready_r <= 1'b0;
      arready_r <= 1'b0;
      wr_busy_r <= 1'b0;
    end else begin
      awready_r <= (wstate_r == W_IDLE) && !aw_fire && !ar_fire && !mem_rd_valid_r;
      arready_r <= (wstate_r == W_IDLE) && !aw_fire && !ar_fire && !awvalid && !mem_rd_valid_r;
      wr_busy_r <= (wstate_r != W_IDLE) || aw_fire;
    end
  end

  // Latch write attributes and decoded location
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_len_r      <= '0;
      aw_excl_r     <= 1'b0;
      aw_pass_r     <= 1'b0;
      early_r       <= 1'b0;
      mem_wr_chip_r <= '0;
      mem_wr_row_r  <= '0;
      mem_wr_col_r  <= '0;
      mem_wr_bank_r <= '0;
    end else if (aw_fire) begin
      aw_len_r      <= awlen;
      aw_excl_r     <= awlock;
      aw_pass_r     <= mon_pass;
      early_r       <= early_resp_en && !awlock;
      mem_wr_chip_r <= aw_chip;
      mem_wr_row_r  <= aw_row;
      mem_wr_col_r  <= aw_col;
      mem_wr_bank_r <= aw_bank;
    end
  end

  // ----------------------------------------------------------------
  // Write channel sequence
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wstate_r <= W_IDLE;
      wready_r <= 1'b0;
      wr_idx_r <= '0;
    end else begin
      case (wstate_r)
        W_IDLE: begin
          if (aw_fire) begin
            wstate_r <= W_DATA;
            wready_r <= 1'b1;
            wr_idx_r <= '0;
          end
        end
        W_DATA: begin
          if (w_fire) begin
            wr_idx_r <= wr_idx_r + LEN_W'(1);
          end
          if (w_last_beat) begin
            wready_r <= 1'b0;
            wstate_r <= W_ISSUE;
          end
        end
        W_ISSUE: begin
          if (mw_fire && mem_wr_last_r) begin
            wstate_r <= W_COMMIT;
          end
        end
        W_COMMIT: begin
          if (mem_wr_done) begin
            wstate_r <= W_RESP;
          end
        end
        W_RESP: begin
          if (b_done_r || b_fire) begin
            wstate_r <= W_IDLE;
          end
        end
        default: begin
          wstate_r <= W_IDLE;
        end
      endcase
    end
  end

  // Write data buffer; a failed exclusive keeps all byte lanes off
  always_ff @(posedge clk) begin
    if (w_fire) begin
      wbuf_data[wr_idx_r] <= wdata;
      wbuf_strb[wr_idx_r] <= (aw_excl_r && !aw_pass_r) ? '0 : wstrb;
    end
  end

  // ----------------------------------------------------------------
  // Drain the buffer to the memory side
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mem_wr_valid_r <= 1'b0;
      mem_wr_data_r  <= '0;
      mem_wr_strb_r  <= '0;
      mem_wr_last_r  <= 1'b0;
      iss_idx_r      <= '0;
    end else if (aw_fire) begin
      iss_idx_r <= '0;
    end else if (mw_load) begin
      mem_wr_valid_r <= 1'b1;
      mem_wr_data_r  <= wbuf_data[iss_idx_r];
      mem_wr_strb_r  <= wbuf_strb[iss_idx_r];
      mem_wr_last_r  <= (iss_idx_r == aw_len_r);
      iss_idx_r      <= iss_idx_r + LEN_W'(1);
    end else if (mw_fire) begin
      mem_wr_valid_r <= 1'b0;
      mem_wr_last_r  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Write response: early after buffering, or after commit
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bvalid_r <= 1'b0;
      bid_r    <= '0;
      bresp_r  <= RESP_OKAY;
      b_done_r <= 1'b0;
    end else begin
      if (aw_fire) begin
        bid_r    <= awid;
        bresp_r  <= (awlock && mon_pass) ? RESP_EXOKAY : RESP_OKAY;
        b_done_r <= 1'b0;
      end
      if (b_fire) begin
        bvalid_r <= 1'b0;
        b_done_r <= 1'b1;
      end else if (wstate_r == W_DATA && w_last_beat && early_r) begin
        bvalid_r <= 1'b1;
      end else if (wstate_r == W_COMMIT && mem_wr_done && !early_r) begin
        bvalid_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read command to the memory side
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mem_rd_valid_r <= 1'b0;
      mem_rd_id_r    <= '0;
      mem_rd_len_r   <= '0;
      mem_rd_size_r  <= '0;
      mem_rd_resp_r  <= RESP_OKAY;
      mem_rd_chip_r  <= '0;
      mem_rd_row_r   <= '0;
      mem_rd_col_r   <= '0;
      mem_rd_bank_r  <= '0;
    end else if (ar_fire) begin
      mem_rd_valid_r <= 1'b1;
      mem_rd_id_r    <= arid;
      mem_rd_len_r   <= arlen;
      mem_rd_size_r  <= arsize;
      mem_rd_resp_r  <= arlock ? RESP_EXOKAY : RESP_OKAY;
      mem_rd_chip_r  <= ar_chip;
      mem_rd_row_r   <= ar_row;
      mem_rd_col_r   <= ar_col;
      mem_rd_bank_r  <= ar_bank;
    end else if (mem_rd_ready) begin
      mem_rd_valid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign awready      = awready_r;
  assign wready       = wready_r;
  assign bvalid       = bvalid_r;
  assign bid          = bid_r;
  assign bresp        = bresp_r;
  assign arready      = arready_r;
  assign mem_wr_valid = mem_wr_valid_r;
  assign mem_wr_data  = mem_wr_data_r;
  assign mem_wr_strb  = mem_wr_strb_r;
  assign mem_wr_last  = mem_wr_last_r;
  assign mem_wr_chip  = mem_wr_chip_r;
  assign mem_wr_row   = mem_wr_row_r;
  assign mem_wr_col   = mem_wr_col_r;
  assign mem_wr_bank  = mem_wr_bank_r;
  assign mem_rd_valid = mem_rd_valid_r;
  assign mem_rd_id    = mem_rd_id_r;
  assign mem_rd_len   = mem_rd_len_r;
  assign mem_rd_size  = mem_rd_size_r;
  assign mem_rd_resp  = mem_rd_resp_r;
  assign mem_rd_chip  = mem_rd_chip_r;
  assign mem_rd_row   = mem_rd_row_r;
  assign mem_rd_col   = mem_rd_col_r;
  assign mem_rd_bank  = mem_rd_bank_r;
  assign wr_busy      = wr_busy_r;

endmodule

// ### afe_properties.sv
// Port checker of the AXI front end
`timescale 1ns/10ps
module afe_chk (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       awvalid,
  input wire logic       awready,
  input wire logic       awlock,
  input wire logic       bvalid,
  input wire logic       bready,
  input wire logic [1:0] bresp,
  input wire logic       arvalid,
  input wire logic       arready,
  input wire logic       arlock,
  input wire logic       mem_wr_valid,
  input wire logic       mem_wr_ready,
  input wire logic [3:0] mem_wr_strb,
  input wire logic       mem_wr_done,
  input wire logic       mem_rd_valid,
  input wire logic [1:0] mem_rd_resp,
  input wire logic       wr_busy
);
  import afe_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic lk_r;
  logic nz_r;
  // Lock flag of the write in flight and any byte sent to memory
  always_ff @(posedge clk) begin
    if (awvalid && awready) lk_r <= awlock;
    if (sys_rst || (awvalid && awready)) nz_r <= 1'b0;
    else if (mem_wr_valid && mem_wr_ready && |mem_wr_strb) nz_r <= 1'b1;
  end
  a_busy_set: assert property (awvalid && awready |=> wr_busy && !awready)
    else $error("busy not set");
  a_no_overlap: assert property (wr_busy |-> !arready && !awready)
    else $error("overlap");
  a_excl_late: assert property ($rose(bvalid) && lk_r |-> $past(mem_wr_done))
    else $error("resp before commit");
  a_fail_mask: assert property (bvalid && lk_r && bresp == RESP_OKAY |-> !nz_r)
    else $error("failed write stored");
  a_ex_written: assert property (bvalid && bresp == RESP_EXOKAY |-> lk_r && nz_r)
    else $error("bad exokay");
  a_plain_okay: assert property (bvalid && !lk_r |-> bresp == RESP_OKAY)
    else $error("bad okay");
  a_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("resp dropped");
  a_rd_resp: assert property (arvalid && arready |=> mem_rd_valid &&
    mem_rd_resp == ($past(arlock) ? RESP_EXOKAY : RESP_OKAY)) else $error("bad read resp");
endmodule
bind afe_axi_front afe_chk i_afe_chk (.*);

// ### afe_mem_model.sv
// Memory-side responder that stalls every other cycle
`timescale 1ns/10ps
module afe_mem_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic mem_wr_valid,
  input wire logic mem_wr_last,
  output logic     mem_wr_ready,
  output logic     mem_wr_done,
  output logic     mem_rd_ready
);
  logic tg_r;
  // Ready on alternate cycles, done pulse after the last beat
  always_ff @(posedge clk) begin
    tg_r        <= !sys_rst && !tg_r;
    mem_wr_done <= !sys_rst && mem_wr_valid && tg_r && mem_wr_last;
  end
  assign mem_wr_ready = tg_r;
  assign mem_rd_ready = tg_r;
endmodule

// ### afe_axi_front_bench.sv
// Self-checking bench of the AXI front end
`timescale 1ns/10ps
module afe_axi_front_bench;
  import afe_pkg::*;
  logic        clk, sys_rst, early_resp_en, awvalid, awready, awlock, wvalid, wready, wlast, bvalid, bready;
  logic        arvalid, arready, arlock, mem_wr_valid, mem_wr_ready, mem_wr_last, mem_wr_done, mem_rd_valid;
  logic        mem_rd_ready, wr_busy;
  logic [1:0]  bresp, mem_rd_resp, mem_wr_bank, mem_rd_bank;
  logic [2:0]  geom_row_code, geom_col_code, awsize, arsize, mem_rd_size;
  logic [3:0]  chip_fmt, awid, bid, arid, awlen, arlen, wstrb, mem_wr_strb, mem_rd_id, mem_rd_len;
  logic [3:0]  mem_wr_chip, mem_rd_chip;
  logic [11:0] mem_wr_col, mem_rd_col;
  logic [15:0] mem_wr_row, mem_rd_row;
  logic [31:0] chip_match, chip_mask, awaddr, araddr, wdata, mem_wr_data, w;
  int          num_errors, samples_checked, cw, rw;
  localparam logic [31:0] RD_ADDR [5] = '{32'h00000100, 32'h40ABCDE4, 32'h8123457C, 32'hC0FFFFFC, 32'hC1000010};
  afe_axi_front i_afe_axi_front (.*);
  afe_mem_model i_afe_mem_model (.*);
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("unexpected %s: expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask
  // Bounded wait for one handshake signal
  task automatic hs(int s);
    int t;
    t = 0;
    while (!(s == 0 ? awready : s == 1 ? wready : s == 2 ? bvalid : s == 3 ? arready :
             s == 4 ? mem_rd_valid : !mem_rd_valid) && t < 99) begin
      tick();
      t++;
    end
    if (t == 99) num_errors++;
  endtask
  task automatic wr(logic [3:0] id, logic [31:0] a, logic [3:0] n, logic lk, logic er, logic [1:0] r);
    {awid, awaddr, awlen, awlock, early_resp_en, awvalid} = {id, a, n, lk, er, 1'b1};
    hs(0);
    tick();
    awvalid = 0;
    for (int i = 0; i <= n; i++) begin
      {wvalid, wlast, wdata} = {1'b1, i == n, a + i};
      hs(1);
      tick();
    end
    wvalid = 0;
    cmp("early bvalid", er && !lk, bvalid);
    hs(2);
    cmp("bresp", r, bresp);
    cmp("bid", id, bid);
    cmp("wr chip", 1, mem_wr_chip);
    tick();
    bready = 1;
    tick();
    bready = 0;
  endtask
  task automatic rd(logic [3:0] id, logic [31:0] a, logic lk, logic [3:0] ch);
    {arid, araddr, arlen, arlock, arvalid} = {id, a, 4'h1, lk, 1'b1};
    hs(3);
    tick();
    arvalid = 0;
    hs(4);
    cmp("rd resp", lk ? RESP_EXOKAY : RESP_OKAY, mem_rd_resp);
    cmp("rd chip", ch, mem_rd_chip);
    cmp("rd id", id, mem_rd_id);
    hs(5);
  endtask
  // Decode over every chip, a miss, and varying geometry and format
  task automatic t_decode();
    for (int k = 0; k < 5; k++) begin
      {geom_row_code, geom_col_code, chip_fmt} = {3'(k), 3'(4 - k), 4'(k * 3)};
      rd(4'(k), RD_ADDR[k], 1'b0, 4'(1 << k));
      w = RD_ADDR[k] >> 2;
      cw = 12 - k;
      rw = 11 + k;
      cmp("rd col", w & ((1 << cw) - 1), mem_rd_col);
      w = w >> cw;
      cmp("rd row", chip_fmt[k & 3] ? w & ((1 << rw) - 1) : (w >> 2) & ((1 << rw) - 1), mem_rd_row);
      cmp("rd bank", chip_fmt[k & 3] ? (w >> rw) & 3 : w & 3, mem_rd_bank);
    end
  endtask
  // Two monitors: a masked hit fails, a near miss passes
  task automatic t_excl();
    rd(0, 32'h100, 1, 1);
    wr(1, 32'h104, 1, 0, 1, RESP_OKAY);
    wr(0, 32'h100, 0, 1, 1, RESP_OKAY);
    rd(0, 32'h100, 1, 1);
    rd(2, 32'h300, 1, 1);
    wr(1, 32'h110, 3, 0, 0, RESP_OKAY);
    wr(0, 32'h100, 0, 1, 1, RESP_EXOKAY);
    wr(2, 32'h300, 0, 1, 0, RESP_EXOKAY);
  endtask
  task automatic report_and_stop();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #50 clk = !clk;
  end
  initial begin
    #400000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    {awvalid, awid, awaddr, awlen, awlock, wvalid, wdata, wlast, bready, arvalid, arid, araddr} = 0;
    {arlen, arlock, early_resp_en, geom_row_code, geom_col_code, chip_fmt} = 0;
    {sys_rst, awsize, arsize, wstrb} = {1'b1, 3'h2, 3'h2, 4'hF};
    {chip_match, chip_mask} = {32'hC0804000, 32'hFFC0C0C0};
    repeat (10) tick();
    sys_rst = 0;
    t_decode();
    t_excl();
    report_and_stop();
  end
endmodule
